// File: fpcmc_top.sv
// Front panel key interpreter, channel mode machine and display sequencer
`timescale 1ns/1ps
module fpcmc_top
	import fpcmc_pkg::*;
#(
	parameter int SEC_CYC_P = SEC_CYC, // Shorten in simulation
	parameter int DEB_CYC_P = DEB_CYC // Shorten in simulation
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic channel_select_key,
	input wire logic run_stop_key,
	input wire logic scan_hold_key,
	input wire logic setpoint_key,
	input wire logic program_key,
	input wire logic exit_key,
	input wire logic process_key,
	input wire logic digit_adjust_key,
	input wire logic digit_select_key,
	input wire fpcmc_req_t bus_req,
	output logic [31:0] rd_data,
	output fpcmc_disp_t disp,
	output logic [2*NCH-1:0] chan_modes,
	output logic [16*NCH-1:0] man_setpoints
);

	////////////////////////////////////////////////////////////////////////
	// Key synchronisers and debounce
	logic [NKEY-1:0] key_raw; // Pins gathered
	logic [NKEY-1:0] sync1_ff; // First stage, read by second only
	logic [NKEY-1:0] sync2_ff;
	logic [NKEY-1:0] smp_ff; // Previous debounce sample
	logic [NKEY-1:0] agree; // Keys equal on two samples
	logic [NKEY-1:0] db_ff; // Debounced levels
	logic [NKEY-1:0] dbp_ff; // Previous debounced levels
	logic [31:0] deb_cnt_ff;
	logic deb_tick;
	logic [NKEY-1:0] press; // One-cycle press pulses
	logic [NKEY-1:0] rel; // One-cycle release pulses

	assign key_raw = {digit_select_key, digit_adjust_key, process_key, exit_key,
		program_key, setpoint_key, scan_hold_key, run_stop_key, channel_select_key};
	assign deb_tick = (deb_cnt_ff == 32'(DEB_CYC_P - 1));
	assign press = db_ff & ~dbp_ff;
	assign rel = ~db_ff & dbp_ff;
	assign agree = ~(sync2_ff ^ smp_ff);

	// Sampling slower than bounce time filters contact chatter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			smp_ff <= '0;
			db_ff <= '0;
			dbp_ff <= '0;
			deb_cnt_ff <= '0;
		end else begin
			sync1_ff <= key_raw;
			sync2_ff <= sync1_ff;
			dbp_ff <= db_ff;
			deb_cnt_ff <= deb_tick ? '0 : deb_cnt_ff + 32'h1;
			// Two agreeing samples needed, so a glitch under one period is dropped
			if (deb_tick) begin
				smp_ff <= sync2_ff;
				db_ff <= (agree & sync2_ff) | (~agree & db_ff);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One second tick
	logic [31:0] sec_cnt_ff;
	logic sec_tick;
	assign sec_tick = (sec_cnt_ff == 32'(SEC_CYC_P - 1));

	// Free-running divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_ff <= '0;
		end else begin
			sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and key events
	logic pdone_ff; // Programming complete
	fpcmc_opt_t opt_ff; // Display option
	logic [7:0] dtime_ff; // Display time, whole seconds
	logic [31:0] rd_data_ff;
	fpcmc_mode_t mode_ff [NCH]; // Channel modes
	fpcmc_mode_t nxt_mode [NCH];
	logic [15:0] msp_ff [NCH]; // Manual setpoints
	logic [NCH-1:0] run_mask; // Channels running a profile
	logic [2:0] sel_ff; // Selected channel, 0 is channel 1
	logic selv_ff; // A channel is selected
	logic dhold_ff; // Display hold mode, read back in status
	logic chord_ff; // Select key used in a chord
	logic cs_held;
	logic hold_req, msp_req, qstop_req, cs_step;
	logic rs_press, sh_press, sp_press, any_press;
	fpcmc_mode_t sel_mode;
	fpcmc_msg_t sel_mode_msg;
	logic [31:0] stat_word;
	logic [31:0] rd_mux;

	assign cs_held = db_ff[K_CSEL];
	assign hold_req = press[K_SH] & cs_held;
	assign msp_req = press[K_SP] & cs_held;
	assign qstop_req = press[K_RS] & cs_held;
	assign cs_step = rel[K_CSEL] & ~chord_ff;
	assign rs_press = press[K_RS] & ~cs_held;
	assign sh_press = press[K_SH] & ~cs_held;
	assign sp_press = press[K_SP] & ~cs_held;
	assign any_press = |press;
	assign sel_mode = mode_ff[sel_ff];
	assign sel_mode_msg = (sel_mode == M_RUN) ? MSG_RUNNING :
		(sel_mode == M_HOLD) ? MSG_HOLDING :
		(sel_mode == M_MAN) ? MSG_MANUAL_SETPOINT_MODE : MSG_STOPPED;

	// Register write port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pdone_ff <= 1'b0;
			opt_ff <= OPT_PROC;
			dtime_ff <= DTIME_RST;
		end else if (bus_req.wr && bus_req.addr == A_CTRL) begin
			pdone_ff <= bus_req.wdata[F_PDONE];
			opt_ff <= fpcmc_opt_t'(bus_req.wdata[F_OPT +: 2]);
		end else if (bus_req.wr && bus_req.addr == A_DTIME) begin
			dtime_ff <= bus_req.wdata[7:0];
		end
	end

	// Read mux; unmapped addresses read zero
	assign stat_word = {11'h000, selv_ff, sel_ff, dhold_ff, 2'h0, chan_modes};
	assign rd_mux = (bus_req.addr == A_CTRL) ? {29'h0, opt_ff, pdone_ff} :
		(bus_req.addr == A_DTIME) ? {24'h0, dtime_ff} :
		(bus_req.addr == A_STAT) ? stat_word :
		(bus_req.addr == A_SETPOINT_KEY) ? {16'h0, msp_ff[sel_ff]} : 32'h0;
	assign rd_data = rd_data_ff;

	// Read data stands the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= bus_req.rd ? rd_mux : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Front panel sequencer
	fpcmc_ui_t ui_ff, nxt_ui;
	fpcmc_msg_t msg_ff, nxt_msg;
	logic shown_ff, nxt_shown; // Run/stop status already shown
	logic [2:0] nxt_sel;
	logic nxt_selv;
	logic [15:0] val_ff, nxt_val; // Setpoint being edited
	logic [1:0] dig_ff, nxt_dig; // Flashing digit
	logic nxt_dhold; // Next display hold mode
	logic [2:0] hchan_ff, nxt_hchan; // Held parameter channel
	logic hsp_ff, nxt_hsp; // Held parameter is setpoint
	logic [2:0] pchan_ff, nxt_pchan; // Process view channel
	logic store, run_go, stop_go, hold_go, qstop;
	logic [3:0] idle_ff; // Seconds since last key
	logic [3:0] age_ff; // Seconds a word has stood
	logic [3:0] nib;

	assign nib = val_ff[4*dig_ff +: 4];

	// Key decode; one event per cycle outside the editor, chords first
	always_comb begin
		nxt_ui = ui_ff;
		nxt_msg = msg_ff;
		nxt_shown = any_press ? 1'b0 : shown_ff;
		nxt_sel = sel_ff;
		nxt_selv = selv_ff;
		nxt_val = val_ff;
		nxt_dig = dig_ff;
		nxt_dhold = dhold_ff;
		nxt_hchan = hchan_ff;
		nxt_hsp = hsp_ff;
		nxt_pchan = pchan_ff;
		{store, run_go, stop_go, hold_go, qstop} = 5'h00;
		if (sec_tick && age_ff >= MSG_S - 4'h1) begin
			nxt_msg = MSG_NONE;
		end
		if (ui_ff == UI_EDIT) begin
			// Editor owns the keys until the exit or program key
			if (press[K_DADJ]) begin
				nxt_val[4*dig_ff +: 4] = (nib == 4'h9) ? 4'h0 : nib + 4'h1;
			end
			if (press[K_DSEL]) begin
				nxt_dig = dig_ff + 2'h1;
			end
			if (press[K_EXIT] || press[K_PROGRAM_KEY]) begin
				// Programming withdrawn mid-edit drops the store
				store = pdone_ff;
				nxt_ui = UI_NORM;
				nxt_msg = MSG_NONE;
			end
		end else if (qstop_req) begin
			qstop = pdone_ff;
			nxt_msg = pdone_ff ? MSG_ALL_STOP : MSG_NOT_PROGRAM_KEY;
			nxt_ui = UI_NORM;
		end else if (hold_req) begin
			nxt_ui = UI_NORM;
			if (!pdone_ff) begin
				nxt_msg = MSG_NOT_PROGRAM_KEY;
			end else if (sel_mode == M_RUN) begin
				hold_go = 1'b1;
				nxt_msg = MSG_HELD;
			end else begin
				nxt_msg = MSG_NOT_RUN;
			end
		end else if (msp_req) begin
			nxt_ui = UI_NORM;
			if (!pdone_ff) begin
				nxt_msg = MSG_NOT_PROGRAM_KEY;
			end else if (sel_mode == M_STOP) begin
				nxt_ui = UI_EDIT;
				nxt_val = msp_ff[sel_ff];
				nxt_dig = 2'h0;
				nxt_msg = MSG_MANUAL_SETPOINT_MODE;
			end else begin
				nxt_msg = sel_mode_msg;
			end
		end else if (cs_step) begin
			nxt_sel = (!selv_ff || sel_ff == LAST_CH) ? 3'h0 : sel_ff + 3'h1;
			nxt_selv = 1'b1;
			nxt_msg = MSG_CHAN;
			nxt_ui = UI_NORM;
		end else if (rs_press && selv_ff) begin
			nxt_ui = UI_NORM;
			nxt_shown = 1'b1;
			if (!shown_ff) begin
				nxt_msg = sel_mode_msg;
			end else if (!pdone_ff) begin
				nxt_msg = MSG_NOT_PROGRAM_KEY;
			end else if (sel_mode == M_RUN) begin
				stop_go = 1'b1;
				nxt_msg = MSG_STOPPED;
			end else begin
				run_go = 1'b1;
				nxt_msg = MSG_RUN_GO;
			end
		end else if (sh_press) begin
			nxt_ui = UI_NORM;
			nxt_dhold = ~dhold_ff;
			nxt_msg = dhold_ff ? MSG_SCAN : MSG_DHOLD;
		end else if (press[K_PROC] && dhold_ff) begin
			nxt_hchan = (hsp_ff || hchan_ff == LAST_CH) ? 3'h0 : hchan_ff + 3'h1;
			nxt_hsp = 1'b0;
			nxt_msg = MSG_NONE;
		end else if (sp_press && dhold_ff) begin
			nxt_hchan = (!hsp_ff || hchan_ff == LAST_CH) ? 3'h0 : hchan_ff + 3'h1;
			nxt_hsp = 1'b1;
			nxt_msg = MSG_NONE;
		end else if (press[K_PROC]) begin
			nxt_pchan = (ui_ff != UI_PVIEW || pchan_ff == LAST_CH) ? 3'h0 :
				pchan_ff + 3'h1;
			nxt_ui = UI_PVIEW;
			nxt_msg = MSG_NONE;
		end else if (any_press && ui_ff == UI_PVIEW) begin
			nxt_ui = UI_NORM;
		end else if (ui_ff == UI_PVIEW && idle_ff >= IDLE_S) begin
			nxt_ui = UI_NORM;
		end
	end

	// Sequencer state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ui_ff <= UI_NORM;
			msg_ff <= MSG_NONE;
			{shown_ff, sel_ff, selv_ff, chord_ff} <= 6'h00;
			{val_ff, dig_ff, dhold_ff} <= 19'h00000;
			{hchan_ff, hsp_ff, pchan_ff} <= 7'h00;
		end else begin
			ui_ff <= nxt_ui;
			msg_ff <= nxt_msg;
			{shown_ff, sel_ff, selv_ff} <= {nxt_shown, nxt_sel, nxt_selv};
			// A chord in the same cycle as the select press still counts
			chord_ff <= (press[K_CSEL] ? 1'b0 : chord_ff) | hold_req | msp_req | qstop_req;
			{val_ff, dig_ff, dhold_ff} <= {nxt_val, nxt_dig, nxt_dhold};
			{hchan_ff, hsp_ff, pchan_ff} <= {nxt_hchan, nxt_hsp, nxt_pchan};
		end
	end

	// Idle and word age timers, saturating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_ff <= '0;
			age_ff <= '0;
		end else begin
			idle_ff <= any_press ? 4'h0 : (sec_tick && idle_ff < IDLE_S) ? idle_ff + 4'h1 : idle_ff;
			age_ff <= (any_press || nxt_msg != msg_ff) ? 4'h0 :
				(sec_tick && age_ff < MSG_S) ? age_ff + 4'h1 : age_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel modes and manual setpoints
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			nxt_mode[i] = mode_ff[i];
			if (qstop && mode_ff[i] == M_RUN) begin
				nxt_mode[i] = M_STOP;
			end else if (3'(i) == sel_ff) begin
				if (stop_go) nxt_mode[i] = M_STOP;
				if (run_go) nxt_mode[i] = M_RUN;
				if (hold_go) nxt_mode[i] = M_HOLD;
				if (store) nxt_mode[i] = M_MAN;
			end
		end
	end

	// One two-bit code per channel keeps modes exclusive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				mode_ff[i] <= M_STOP;
				msp_ff[i] <= SETPOINT_KEY_RST;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				mode_ff[i] <= nxt_mode[i];
				if (store && 3'(i) == sel_ff) msp_ff[i] <= val_ff;
			end
		end
	end

	// Flattened views for the regulation loops
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			chan_modes[2*i +: 2] = mode_ff[i];
			man_setpoints[16*i +: 16] = msp_ff[i];
			run_mask[i] = (mode_ff[i] == M_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Display scan
	logic [7:0] scan_cnt_ff; // Seconds on current parameter
	logic [2:0] scan_ch_ff;
	logic scan_sp_ff; // Showing setpoint phase
	logic scan_adv;
	logic [3:0] nr; // {found, channel}
	logic [2:0] nxt_sch;
	logic nxt_ssp;
	fpcmc_disp_t nxt_disp;
	fpcmc_disp_t disp_ff;

	// Next running channel after cur, wrapping, cur itself last
	function automatic logic [3:0] next_run(input logic [2:0] cur, input logic [NCH-1:0] m);
		logic [3:0] r;
		logic [2:0] c;
		r = {1'b0, cur};
		for (int k = NCH; k >= 1; k--) begin
			c = 3'((int'(cur) + k) % NCH);
			if (m[c]) r = {1'b1, c};
		end
		return r;
	endfunction

	assign scan_adv = sec_tick && !dhold_ff && (scan_cnt_ff + 8'h1 >= dtime_ff);
	assign nr = next_run(scan_ch_ff, run_mask);

	// Step order per display option
	always_comb begin
		nxt_sch = scan_ch_ff;
		nxt_ssp = 1'b0;
		case (opt_ff)
			OPT_SP: begin
				nxt_sch = nr[2:0];
				nxt_ssp = 1'b1;
			end
			OPT_BOTH: begin
				if (!scan_sp_ff && run_mask[scan_ch_ff]) begin
					nxt_ssp = 1'b1;
				end else begin
					nxt_sch = nr[2:0];
				end
			end
			default: begin
				nxt_sch = (scan_ch_ff == LAST_CH) ? 3'h0 : scan_ch_ff + 3'h1;
			end
		endcase
	end

	// Dwell counter and scan position
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_cnt_ff <= '0;
			{scan_ch_ff, scan_sp_ff} <= 4'h0;
		end else if (scan_adv) begin
			scan_cnt_ff <= '0;
			{scan_ch_ff, scan_sp_ff} <= {nxt_sch, nxt_ssp};
		end else if (sec_tick && !dhold_ff) begin
			scan_cnt_ff <= scan_cnt_ff + 8'h1;
		end
	end

	// Display selection: editor, word, process view, hold, scan
	always_comb begin
		nxt_disp = '{msg: MSG_NONE, chan: scan_ch_ff, show_sp: scan_sp_ff,
			digit: 2'h0, value: 16'h0000};
		if (ui_ff == UI_EDIT) begin
			nxt_disp = '{msg: MSG_MANUAL_SETPOINT_MODE, chan: sel_ff, show_sp: 1'b1,
				digit: dig_ff, value: val_ff};
		end else if (msg_ff != MSG_NONE) begin
			nxt_disp.msg = msg_ff;
			nxt_disp.chan = sel_ff;
		end else if (ui_ff == UI_PVIEW) begin
			nxt_disp.chan = pchan_ff;
			nxt_disp.show_sp = 1'b0;
		end else if (dhold_ff) begin
			nxt_disp.chan = hchan_ff;
			nxt_disp.show_sp = hsp_ff;
		end else if (opt_ff != OPT_PROC && run_mask == '0) begin
			nxt_disp.msg = MSG_NO_RUN;
		end
	end

	// Display content registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_ff <= '0;
		end else begin
			disp_ff <= nxt_disp;
		end
	end
	assign disp = disp_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_refuse_unprog: assert property (@(posedge clk) disable iff (!rst_n)
		!pdone_ff |=> $stable(chan_modes)) else $error("mode changed before programming");
	a_quick_stop: assert property (@(posedge clk) disable iff (!rst_n)
		qstop_req && pdone_ff && ui_ff != UI_EDIT |=> run_mask == '0)
		else $error("quick stop left a channel running");
	a_hold_refused: assert property (@(posedge clk) disable iff (!rst_n)
		hold_req && !qstop_req && ui_ff != UI_EDIT && sel_mode != M_RUN |=>
		$stable(chan_modes) ##1 disp.msg == MSG_NOT_RUN || !pdone_ff)
		else $error("hold on idle channel acted");
	a_edit_entry: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ui_ff == UI_EDIT) |-> $past(sel_mode) == M_STOP && $past(pdone_ff))
		else $error("editor opened on non-stopped channel");
	a_store_manual: assert property (@(posedge clk) disable iff (!rst_n)
		ui_ff == UI_EDIT && pdone_ff && press[K_EXIT] |=>
		sel_mode == M_MAN && ui_ff == UI_NORM &&
		msp_ff[sel_ff] == $past(val_ff)) else $error("setpoint not stored");
	a_select_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		cs_step && ui_ff != UI_EDIT && selv_ff && sel_ff == LAST_CH && !press[K_RS] &&
		!press[K_SP] && !press[K_SH] |=> sel_ff == 3'h0 ##1 disp.msg == MSG_CHAN)
		else $error("channel select did not wrap");
	a_first_show: assert property (@(posedge clk) disable iff (!rst_n)
		rs_press && selv_ff && !shown_ff && ui_ff != UI_EDIT && !cs_step |=>
		$stable(chan_modes) && msg_ff == $past(sel_mode_msg))
		else $error("first run/stop press changed mode");
	a_dhold_modes: assert property (@(posedge clk) disable iff (!rst_n)
		sh_press && ui_ff != UI_EDIT && !cs_step && !rs_press |=> $stable(chan_modes))
		else $error("display hold changed a mode");
	a_pview_timeout: assert property (@(posedge clk) disable iff (!rst_n)
		ui_ff == UI_PVIEW && idle_ff >= IDLE_S && !any_press |=> ui_ff == UI_NORM)
		else $error("process view did not time out");

endmodule // fpcmc_top

// File: fpcmc_pkg.sv
// Shared constants, types and register map for the front panel channel mode control
package fpcmc_pkg;

	// Clock and time bases
	localparam int CLK_HZ = 200_000_000; // System clock rate
	localparam int TICK_S = 1; // Scan and timeout resolution, seconds
	localparam int SEC_CYC = CLK_HZ * TICK_S; // Cycles per second tick
	localparam int DEB_MS = 10; // Key sampling period, ms
	localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS; // Cycles per key sample
	localparam logic [3:0] IDLE_S = 4'hA; // Process view inactivity timeout, s
	localparam logic [3:0] MSG_S = 4'h2; // Status word dwell, s

	// Channels and keys
	localparam int NCH = 7;
	localparam logic [2:0] LAST_CH = 3'h6;
	localparam int NKEY = 9;
	localparam int K_CSEL = 0;
	localparam int K_RS = 1;
	localparam int K_SH = 2;
	localparam int K_SP = 3;
	localparam int K_PROGRAM_KEY = 4;
	localparam int K_EXIT = 5;
	localparam int K_PROC = 6;
	localparam int K_DADJ = 7;
	localparam int K_DSEL = 8;

	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_DTIME = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_SETPOINT_KEY = 8'h0C;
	// Field positions
	localparam int F_PDONE = 0; // CTRL: programming complete
	localparam int F_OPT = 1; // CTRL: display option, 2 bits
	localparam int F_DHOLD = 16; // STAT: display hold flag
	localparam int F_SEL = 17; // STAT: selected channel, 3 bits
	localparam int F_SELV = 20; // STAT: a channel has been selected
	localparam logic [7:0] DTIME_RST = 8'h02; // Display time reset, s
	localparam logic [15:0] SETPOINT_KEY_RST = 16'h0000; // Manual setpoint reset

	typedef enum logic [1:0] {M_STOP = 2'b00, M_RUN = 2'b01, M_HOLD = 2'b10,
		M_MAN = 2'b11} fpcmc_mode_t;
	typedef enum logic [1:0] {OPT_PROC = 2'b00, OPT_SP = 2'b01, OPT_BOTH = 2'b10}
		fpcmc_opt_t;
	typedef enum logic [1:0] {UI_NORM = 2'b00, UI_EDIT = 2'b01, UI_PVIEW = 2'b10}
		fpcmc_ui_t;
	typedef enum logic [3:0] {MSG_NONE = 4'h0, MSG_CHAN = 4'h1, MSG_RUNNING = 4'h2,
		MSG_HOLDING = 4'h3, MSG_STOPPED = 4'h4, MSG_MANUAL_SETPOINT_MODE = 4'h5,
		MSG_RUN_GO = 4'h6, MSG_HELD = 4'h7, MSG_NOT_RUN = 4'h8, MSG_NO_RUN = 4'h9,
		MSG_SCAN = 4'hA, MSG_DHOLD = 4'hB, MSG_NOT_PROGRAM_KEY = 4'hC,
		MSG_ALL_STOP = 4'hD} fpcmc_msg_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} fpcmc_req_t;

	// Display content: word, channel, which value, flashing digit, edit value
	typedef struct packed {
		fpcmc_msg_t msg;
		logic [2:0] chan;
		logic show_sp;
		logic [1:0] digit;
		logic [15:0] value;
	} fpcmc_disp_t;

endpackage

// File: fpcmc_operator.sv
// Operator model: presses, holds and releases the front panel keys
`timescale 1ns/1ps
module fpcmc_operator
	import fpcmc_pkg::*;
(
	input wire logic clk,
	output logic [NKEY-1:0] keys
);
	// All keys up at time zero
	initial begin
		keys = '0;
	end

	////////////////////////////////////////////////////////////////
	// Hold keys a, add keys b while a is held, release all together
	// A short hold makes a bounce that the debouncer must ignore
	task automatic chord(input logic [NKEY-1:0] a, input logic [NKEY-1:0] b, input int hold);
		if (a != '0) begin
			@(posedge clk) keys <= a;
			repeat (hold) @(posedge clk);
		end
		@(posedge clk) keys <= a | b;
		repeat (hold) @(posedge clk);
		@(posedge clk) keys <= '0;
		repeat (hold) @(posedge clk);
	endtask
endmodule // fpcmc_operator

// File: tb_top.sv
// Self-checking bench for the front panel channel mode control
`timescale 1ns/1ps
module tb_top
	import fpcmc_pkg::*;
;
	localparam int SEC = 100; // Short second keeps the run brief
	localparam logic [NKEY-1:0] CS = 9'h001; // Key masks, one bit per key
	localparam logic [NKEY-1:0] RS = 9'h002;
	localparam logic [NKEY-1:0] SH = 9'h004;
	localparam logic [NKEY-1:0] SP = 9'h008;
	localparam logic [NKEY-1:0] EX = 9'h020;
	localparam logic [NKEY-1:0] PR = 9'h040;
	localparam logic [NKEY-1:0] DA = 9'h080;
	localparam logic [NKEY-1:0] DS = 9'h100;
	typedef struct packed {
		logic [NKEY-1:0] a;
		logic [NKEY-1:0] b;
		fpcmc_msg_t msg;
		fpcmc_mode_t mode;
	} fpcmc_row_t;
	// Held keys, added keys, word shown, channel 1 mode after
	localparam fpcmc_row_t ROWS [12] = '{'{9'h000, CS, MSG_CHAN, M_STOP},
		'{9'h000, RS, MSG_STOPPED, M_STOP}, '{9'h000, RS, MSG_RUN_GO, M_RUN},
		'{9'h000, RS, MSG_STOPPED, M_STOP}, '{9'h000, RS, MSG_RUN_GO, M_RUN},
		'{CS, SH, MSG_HELD, M_HOLD}, '{CS, SH, MSG_NOT_RUN, M_HOLD},
		'{9'h000, RS, MSG_HOLDING, M_HOLD}, '{9'h000, RS, MSG_RUN_GO, M_RUN},
		'{CS, SP, MSG_RUNNING, M_RUN}, '{CS, RS, MSG_ALL_STOP, M_STOP},
		'{CS, SP, MSG_MANUAL_SETPOINT_MODE, M_STOP}};
	logic clk = 1'b0;
	logic rst_n = 1'b0; // Held low from time zero
	logic [NKEY-1:0] keys;
	fpcmc_req_t req = '0;
	logic [31:0] rd_data;
	logic [31:0] d;
	logic [2:0] c;
	fpcmc_disp_t disp;
	logic [2*NCH-1:0] chan_modes;
	logic [16*NCH-1:0] man_setpoints;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;

	always #2.5 clk = ~clk;

	fpcmc_operator i_op (.clk(clk), .keys(keys));
	fpcmc_top #(.SEC_CYC_P(SEC), .DEB_CYC_P(4)) i_dut (.clk(clk), .rst_n(rst_n),
		.channel_select_key(keys[K_CSEL]), .run_stop_key(keys[K_RS]),
		.scan_hold_key(keys[K_SH]), .setpoint_key(keys[K_SP]),
		.program_key(keys[K_PROGRAM_KEY]), .exit_key(keys[K_EXIT]),
		.process_key(keys[K_PROC]), .digit_adjust_key(keys[K_DADJ]),
		.digit_select_key(keys[K_DSEL]), .bus_req(req), .rd_data(rd_data),
		.disp(disp), .chan_modes(chan_modes), .man_setpoints(man_setpoints));

	////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or the hang guard
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// Case-equality compare, so an unknown never matches
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk) req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clk) req <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk) req <= '0;
		#1 d = rd_data;
	endtask

	// Key action, then let debounce and display settle
	task automatic push(input logic [NKEY-1:0] a, input logic [NKEY-1:0] b);
		i_op.chord(a, b, 16);
		repeat (8) @(posedge clk);
		#1;
	endtask

	// Asynchronous reset held for two cycles
	task automatic do_reset();
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// Mode keys before programming is complete
		push(9'h000, CS);
		push(9'h000, RS);
		push(9'h000, RS);
		cmp(chan_modes, 32'h0);
		cmp(disp.msg, MSG_NOT_PROGRAM_KEY);
		// Second reset in mid-run restores every default
		do_reset();
		#1;
		cmp(chan_modes, 32'h0);
		cmp(disp, 32'h0);
		bus_rd(A_DTIME);
		cmp(d, 32'h2);
		bus_rd(A_CTRL);
		cmp(d, 32'h0);
		bus_rd(8'h10);
		cmp(d, 32'h0);
		bus_wr(A_CTRL, 32'h1);
		// Table walk through the channel mode machine
		foreach (ROWS[i]) begin
			push(ROWS[i].a, ROWS[i].b);
			cmp(disp.msg, ROWS[i].msg);
			cmp(chan_modes, ROWS[i].mode);
			cmp(disp.chan, 32'h0);
		end
		// Editor: low digit to 1, next digit to 1, exit stores 11
		push(9'h000, DA);
		cmp(disp.value, 32'h0001);
		push(9'h000, DS);
		cmp(disp.digit, 32'h1);
		push(9'h000, DA);
		cmp(disp.value, 32'h0011);
		push(9'h000, EX);
		cmp(chan_modes, M_MAN);
		cmp(man_setpoints[15:0], 32'h0011);
		bus_rd(A_SETPOINT_KEY);
		cmp(d, 32'h0011);
		// Process scan, two seconds per channel, all channels
		bus_wr(A_DTIME, 32'h2);
		repeat (3 * SEC) @(posedge clk);
		c = disp.chan;
		for (int n = 0; n < 3 * SEC && disp.chan == c; n++) @(posedge clk);
		repeat (SEC) @(posedge clk);
		c = disp.chan;
		repeat (2 * SEC) @(posedge clk);
		cmp(disp.chan, (c == LAST_CH) ? 3'h0 : c + 3'h1);
		cmp(disp.show_sp, 32'h0);
		// Setpoint option with nothing running
		bus_wr(A_CTRL, 32'h3);
		repeat (5 * SEC) @(posedge clk);
		cmp(disp.msg, MSG_NO_RUN);
		// Display hold leaves modes alone, setpoint key picks the value
		push(9'h000, SH);
		cmp(disp.msg, MSG_DHOLD);
		bus_rd(A_STAT);
		cmp(d, 32'h0011_0003);
		push(9'h000, SP);
		cmp({disp.show_sp, disp.chan}, 32'h8);
		push(9'h000, SP);
		repeat (4 * SEC) @(posedge clk);
		cmp({disp.show_sp, disp.chan}, 32'h9);
		push(9'h000, SH);
		cmp(disp.msg, MSG_SCAN);
		// Process view steps, then times out after ten idle seconds
		push(9'h000, PR);
		cmp({disp.show_sp, disp.chan}, 32'h0);
		push(9'h000, PR);
		repeat (5 * SEC) @(posedge clk);
		cmp({disp.show_sp, disp.chan}, 32'h1);
		repeat (8 * SEC) @(posedge clk);
		cmp(disp.msg, MSG_NO_RUN);
		// A two-cycle bounce must not step the selection
		i_op.chord(9'h000, CS, 1);
		repeat (30) @(posedge clk);
		bus_rd(A_STAT);
		cmp(d[19:17], 32'h0);
		// Seven presses walk channels 2..7 and wrap to 1
		for (int i = 1; i <= NCH; i++) begin
			push(9'h000, CS);
			bus_rd(A_STAT);
			cmp(d[19:17], i % NCH);
			cmp(disp.msg, MSG_CHAN);
		end
		// Combined option: a lone running channel shows process, then setpoint
		push(9'h000, RS);
		cmp(disp.msg, MSG_MANUAL_SETPOINT_MODE);
		push(9'h000, RS);
		cmp(chan_modes, M_RUN);
		bus_wr(A_CTRL, 32'h5);
		repeat (3 * SEC) @(posedge clk);
		#1 d = {disp.show_sp, disp.chan};
		repeat (2 * SEC) @(posedge clk);
		#1;
		cmp(d[2:0], 32'h0);
		cmp({disp.show_sp, disp.chan}, {~d[3], 3'h0});
		tally_and_finish();
	end
endmodule // tb_top
